// [core/bt_defines.vh]
// constants for the pattern tester error insertion and status counters
`ifndef BT_DEFINES_VH
`define BT_DEFINES_VH
// register indexes; byte address is four times the index
`define BT_IDX_MON_CTRL     8'h60
`define BT_IDX_INJ_CTRL     8'h68
`define BT_IDX_LIVE_STATUS  8'h6C
`define BT_IDX_LATCHED      8'h6E
`define BT_IDX_IRQ_EN       8'h70
`define BT_IDX_ERR_LOW      8'h74
`define BT_IDX_ERR_HIGH     8'h76
`define BT_IDX_BIT_LOW      8'h78
`define BT_IDX_BIT_HIGH     8'h7A
`define BT_ADDR_W           12
`define BT_ADDR_LSB         2
`define BT_IDX_W            10
// monitor control fields
`define BT_MON_SRC_BIT      7
`define BT_MON_LOCAL_BIT    6
// injection control fields
`define BT_INJ_RATE_HI      5
`define BT_INJ_RATE_LO      3
`define BT_INJ_SINGLE_EN    2
`define BT_INJ_SOFT         1
`define BT_INJ_SRC          0
`define BT_INJ_MASK         16'h003F
// status, latched and enable fields share positions
`define BT_ST_DONE          3
`define BT_ST_BITERR        2
`define BT_ST_NONZERO       1
`define BT_ST_OOS           0
`define BT_LAT_MASK         16'h000F
`define BT_MON_MASK         16'h00C0
// counter widths and saturation values
`define BT_ERR_W            24
`define BT_BIT_W            32
`define BT_ERR_MAX          24'hFFFFFF
`define BT_BIT_MAX          32'hFFFFFFFF
`define BT_ERR_ONE          24'h000001
`define BT_BIT_ONE          32'h00000001
// rate period counts, one error per ten to the n bits
`define BT_RATE_W           3
`define BT_PER_W            24
`define BT_PER_1            24'h00000A
`define BT_PER_2            24'h000064
`define BT_PER_3            24'h0003E8
`define BT_PER_4            24'h002710
`define BT_PER_5            24'h0186A0
`define BT_PER_6            24'h0F4240
`define BT_PER_7            24'h989680
`define BT_RATE_OFF         3'h0
`endif

// [core/bt_error_status.v]
// pattern tester error insertion, status, latched events and counters
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "bt_defines.vh"
// Notes on behaviour
// - rate field inverts one bit per 10^n
// - rate starts and stops on write; other changes after next error
// - single error enable gates single insertion
// - soft bit rising edge inverts one bit
// - many toggles between opportunities, one error
// - source select picks soft bit or pin
// - update source picks local or global request
// - done rises on update, falls with request
// - nonzero status follows count, cleared by update unless an error arrives in the update cycle
// - out of sync status mirrors pattern lock
// - done rise sets latched done flag
// - detected bit error sets latched flag
// - nonzero rise sets latched nonzero flag
// - any sync change sets latched flag
// - done interrupt ignores port global enable
// - other interrupts need port global enable
// - error counter 24 bits, saturating
// - error counter frozen while out of sync
// - bit counter 32 bits, saturating
// - bit counter frozen while out of sync
// - error count split low 16, high 8
// - bit count split low 16, high 16
// - readable counts change only on update
module bt_error_status (
   input  wire        CLK_I,
   input  wire        RESET_N_I,
   input  wire        CE_I,
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [11:0] PADDR_I,
   input  wire [31:0] PWDATA_I,
   output wire [31:0] PRDATA_O,
   output wire        PREADY_O,
   output wire        PSLVERR_O,
   input  wire        PM_UPDATE_REQUEST_I,
   input  wire        PORT_STATUS_IRQ_EN_I,
   input  wire        EXT_ERROR_INSERT_PIN_I,
   input  wire        TX_BIT_VALID_I,
   input  wire        TX_DATA_I,
   output wire        TX_BIT_VALID_O,
   output wire        TX_DATA_O,
   input  wire        RX_BIT_VALID_I,
   input  wire        RX_BIT_ERROR_I,
   input  wire        OUT_OF_SYNC_I,
   output wire        IRQ_O
);

   // software visible control
   reg [15:0]              mon_ctrl_ff;
   reg [15:0]              inj_ctrl_ff;
   reg [3:0]               irq_en_ff;
   reg [3:0]               latched_ff;
   reg [31:0]              prdata_ff;
   // insertion state
   reg                     trig_prev_ff;
   reg                     single_pend_ff;
   reg [`BT_RATE_W-1:0]    rate_act_ff;
   reg [`BT_RATE_W-1:0]    rate_new_ff;
   reg [`BT_PER_W-1:0]     rate_cnt_ff;
   reg                     tx_valid_ff;
   reg                     tx_data_ff;
   // monitoring state
   reg                     req_prev_ff;
   reg                     done_ff;
   reg                     nonzero_prev_ff;
   reg                     oos_ff;
   reg                     oos_prev_ff;
   reg                     done_prev_ff;
   wire [`BT_ERR_W-1:0]    err_cnt;
   wire [`BT_ERR_W-1:0]    err_snap;
   wire [`BT_BIT_W-1:0]    bit_snap;

   // bus decode
   wire [`BT_IDX_W-1:0] idx    = PADDR_I[`BT_ADDR_W-1:`BT_ADDR_LSB];
   wire                 setup  = PSEL_I & ~PENABLE_I;
   wire                 wr_acc = PSEL_I & PENABLE_I & PWRITE_I & CE_I;
   reg                  mapped;
   reg  [31:0]          rd_mux;

   // rate period lookup, a constant table
   function [`BT_PER_W-1:0] period_of;
      input [`BT_RATE_W-1:0] n;
      begin
         case (n)
            3'h1:    period_of = `BT_PER_1;
            3'h2:    period_of = `BT_PER_2;
            3'h3:    period_of = `BT_PER_3;
            3'h4:    period_of = `BT_PER_4;
            3'h5:    period_of = `BT_PER_5;
            3'h6:    period_of = `BT_PER_6;
            3'h7:    period_of = `BT_PER_7;
            default: period_of = `BT_PER_1;
         endcase
      end
   endfunction

   // field views
   wire                  src_pin    = inj_ctrl_ff[`BT_INJ_SRC];
   wire                  single_en  = inj_ctrl_ff[`BT_INJ_SINGLE_EN];
   wire                  soft_ins   = inj_ctrl_ff[`BT_INJ_SOFT];
   wire                  upd_src    = mon_ctrl_ff[`BT_MON_SRC_BIT];
   wire                  local_upd  = mon_ctrl_ff[`BT_MON_LOCAL_BIT];
   wire [`BT_RATE_W-1:0] wr_rate    = PWDATA_I[`BT_INJ_RATE_HI:`BT_INJ_RATE_LO];
   wire                  inj_wr     = wr_acc & (idx == `BT_IDX_INJ_CTRL);

   // trigger source; a source flip while high looks like an edge
   wire trig      = src_pin ? EXT_ERROR_INSERT_PIN_I : soft_ins;
   wire trig_rise = trig & ~trig_prev_ff;

   // rate insertion due when the bit count reaches the period
   wire rate_on  = (rate_act_ff != `BT_RATE_OFF);
   wire rate_hit = rate_on & TX_BIT_VALID_I &
                   (rate_cnt_ff == period_of(rate_act_ff) - `BT_ERR_ONE);
   wire single_hit = single_pend_ff & TX_BIT_VALID_I;
   wire flip_bit   = rate_hit | single_hit;

   // update request selection and edge
   wire req      = upd_src ? PM_UPDATE_REQUEST_I : local_upd;
   wire req_rise = req & ~req_prev_ff;

   // live status view
   wire nonzero = (err_cnt != {`BT_ERR_W{1'b0}});
   wire [15:0] live_status = {12'h000, done_ff, 1'b0, nonzero, oos_ff};

   // receive events counted only while locked
   wire rx_count = RX_BIT_VALID_I & ~oos_ff;
   wire rx_err   = rx_count & RX_BIT_ERROR_I;

   // read mux and address map
   always @* begin
      mapped = 1'b1;
      rd_mux = 32'h00000000;
      case (idx)
         `BT_IDX_MON_CTRL:    rd_mux = {16'h0000, mon_ctrl_ff};
         `BT_IDX_INJ_CTRL:    rd_mux = {16'h0000, inj_ctrl_ff};
         `BT_IDX_LIVE_STATUS: rd_mux = {16'h0000, live_status};
         `BT_IDX_LATCHED:     rd_mux = {28'h0000000, latched_ff};
         `BT_IDX_IRQ_EN:      rd_mux = {28'h0000000, irq_en_ff};
         `BT_IDX_ERR_LOW:     rd_mux = {16'h0000, err_snap[15:0]};
         `BT_IDX_ERR_HIGH:    rd_mux = {24'h000000, err_snap[23:16]};
         `BT_IDX_BIT_LOW:     rd_mux = {16'h0000, bit_snap[15:0]};
         `BT_IDX_BIT_HIGH:    rd_mux = {16'h0000, bit_snap[31:16]};
         default:             mapped = 1'b0;
      endcase
   end

   // zero wait state slave; error answer on unmapped index
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
   assign PRDATA_O  = prdata_ff;

   // read data captured in setup so it comes from a flop
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         prdata_ff <= 32'h00000000;
      end else if (CE_I && setup) begin
         prdata_ff <= PWRITE_I ? 32'h00000000 : rd_mux;
      end
   end

   // control registers written in the access phase
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         mon_ctrl_ff <= 16'h0000;
         inj_ctrl_ff <= 16'h0000;
         irq_en_ff   <= 4'h0;
      end else if (wr_acc) begin
         if (idx == `BT_IDX_MON_CTRL) begin
            mon_ctrl_ff <= PWDATA_I[15:0] & `BT_MON_MASK;
         end
         if (idx == `BT_IDX_INJ_CTRL) begin
            inj_ctrl_ff <= PWDATA_I[15:0] & `BT_INJ_MASK;
         end
         if (idx == `BT_IDX_IRQ_EN) begin
            irq_en_ff <= PWDATA_I[3:0];
         end
      end
   end

   // single error request; held until a bit goes out, so extra
   // toggles in between fold into the one pending error
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         trig_prev_ff   <= 1'b0;
         single_pend_ff <= 1'b0;
      end else if (CE_I) begin
         trig_prev_ff <= trig;
         if (trig_rise && single_en) begin
            single_pend_ff <= 1'b1;
         end else if (single_hit) begin
            single_pend_ff <= 1'b0;
         end
      end
   end

   // rate insertion; a new rate waits for the current error
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rate_act_ff <= `BT_RATE_OFF;
         rate_new_ff <= `BT_RATE_OFF;
         rate_cnt_ff <= {`BT_PER_W{1'b0}};
      end else if (CE_I) begin
         if (inj_wr) begin
            rate_new_ff <= wr_rate;
            if (!rate_on || wr_rate == `BT_RATE_OFF) begin
               rate_act_ff <= wr_rate;
               rate_cnt_ff <= {`BT_PER_W{1'b0}};
            end
         end
         if (rate_hit) begin
            rate_cnt_ff <= {`BT_PER_W{1'b0}};
            if (!inj_wr) begin
               rate_act_ff <= rate_new_ff;
            end else if (wr_rate != `BT_RATE_OFF) begin
               rate_act_ff <= wr_rate;
            end
         end else if (rate_on && TX_BIT_VALID_I && !inj_wr) begin
            rate_cnt_ff <= rate_cnt_ff + `BT_ERR_ONE;
         end
      end
   end

   // outgoing bit, inverted on the chosen opportunity
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         tx_valid_ff <= 1'b0;
         tx_data_ff  <= 1'b0;
      end else if (CE_I) begin
         tx_valid_ff <= TX_BIT_VALID_I;
         if (TX_BIT_VALID_I) begin
            tx_data_ff <= TX_DATA_I ^ flip_bit;
         end
      end
   end
   assign TX_BIT_VALID_O = tx_valid_ff;
   assign TX_DATA_O      = tx_data_ff;

   // live tallies with readable copies; the gating above keeps them
   // still while out of sync, and the copies move only on update
   bt_sat_count #(
      .W         (`BT_ERR_W)
   ) i_err_tally (
      .clk_i     (CLK_I),
      .reset_n_i (RESET_N_I),
      .ce_i      (CE_I),
      .inc_i     (rx_err),
      .take_i    (req_rise),
      .count_o   (err_cnt),
      .snap_o    (err_snap)
   );

   // received bit tally, same logic at the wider width; its live
   // count is never read here, only the copy taken on update
   bt_sat_count #(
      .W         (`BT_BIT_W)
   ) i_bit_tally (
      .clk_i     (CLK_I),
      .reset_n_i (RESET_N_I),
      .ce_i      (CE_I),
      .inc_i     (rx_count),
      .take_i    (req_rise),
      .count_o   (),
      .snap_o    (bit_snap)
   );

   // update done status follows the request handshake
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         req_prev_ff <= 1'b0;
         done_ff     <= 1'b0;
      end else if (CE_I) begin
         req_prev_ff <= req;
         if (!req) begin
            done_ff <= 1'b0;
         end else if (req_rise) begin
            done_ff <= 1'b1;
         end
      end
   end

   // sync status and edge history for the latched flags
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         oos_ff          <= 1'b0;
         oos_prev_ff     <= 1'b0;
         nonzero_prev_ff <= 1'b0;
         done_prev_ff    <= 1'b0;
      end else if (CE_I) begin
         oos_ff          <= OUT_OF_SYNC_I;
         oos_prev_ff     <= oos_ff;
         nonzero_prev_ff <= nonzero;
         done_prev_ff    <= done_ff;
      end
   end

   // latched events; a new event beats a same-cycle clear
   wire [3:0] lat_set;
   assign lat_set[`BT_ST_DONE]    = done_ff & ~done_prev_ff;
   assign lat_set[`BT_ST_BITERR]  = RX_BIT_VALID_I & RX_BIT_ERROR_I;
   assign lat_set[`BT_ST_NONZERO] = nonzero & ~nonzero_prev_ff;
   assign lat_set[`BT_ST_OOS]     = oos_ff ^ oos_prev_ff;
   wire [3:0] lat_clr = (wr_acc && idx == `BT_IDX_LATCHED) ?
                        PWDATA_I[3:0] : 4'h0;

   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         latched_ff <= 4'h0;
      end else if (CE_I) begin
         latched_ff <= (latched_ff & ~lat_clr) | lat_set;
      end
   end

   // interrupt: done needs only its enable, rest need port enable
   wire [3:0] lat_act = latched_ff & irq_en_ff;
   assign IRQ_O = lat_act[`BT_ST_DONE] |
                  (PORT_STATUS_IRQ_EN_I &
                   (lat_act[`BT_ST_BITERR] | lat_act[`BT_ST_NONZERO] |
                    lat_act[`BT_ST_OOS]));

endmodule

// saturating event tally with a copy for software; one instance
// per counter so both widths share the same update behaviour
module bt_sat_count #(
   parameter W = 24
) (
   input  wire         clk_i,
   input  wire         reset_n_i,
   input  wire         ce_i,
   input  wire         inc_i,
   input  wire         take_i,
   output wire [W-1:0] count_o,
   output wire [W-1:0] snap_o
);

   reg  [W-1:0] cnt_ff;
   reg  [W-1:0] snap_ff;

   // all ones is the ceiling; held there until the next update
   wire         at_max  = &cnt_ff;
   wire [W-1:0] one     = {{(W-1){1'b0}}, 1'b1};
   wire [W-1:0] restart = {{(W-1){1'b0}}, inc_i};

   // take copies the live count and restarts it; an event in the
   // take cycle starts the new interval at one instead of being lost
   // ce low holds both the live count and the copy
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_ff  <= {W{1'b0}};
         snap_ff <= {W{1'b0}};
      end else if (ce_i) begin
         if (take_i) begin
            snap_ff <= cnt_ff;
            cnt_ff  <= restart;
         end else if (inc_i && !at_max) begin
            cnt_ff <= cnt_ff + one;
         end
      end
   end

   // readable copy only moves on take, never with the live count
   assign count_o = cnt_ff;
   assign snap_o  = snap_ff;

endmodule

// [verification/bt_es_monitor.sv]
// checker for bus answers and transmit path of the tester block
`timescale 1ns/1ps
`include "bt_defines.vh"
module bt_es_monitor (
   input wire        CLK_I,
   input wire        RESET_N_I,
   input wire        PSEL_I,
   input wire        PENABLE_I,
   input wire        PWRITE_I,
   input wire [11:0] PADDR_I,
   input wire [31:0] PRDATA_O,
   input wire        PREADY_O,
   input wire        PSLVERR_O,
   input wire        TX_BIT_VALID_I,
   input wire        TX_BIT_VALID_O,
   input wire        TX_DATA_O
);
   // mapped indexes; everything else must be refused
   wire [9:0] idx    = PADDR_I[11:2];
   wire       mapped = idx == `BT_IDX_MON_CTRL || idx == `BT_IDX_INJ_CTRL || idx == `BT_IDX_LIVE_STATUS ||
                       idx == `BT_IDX_LATCHED || idx == `BT_IDX_IRQ_EN || idx == `BT_IDX_ERR_LOW ||
                       idx == `BT_IDX_ERR_HIGH || idx == `BT_IDX_BIT_LOW || idx == `BT_IDX_BIT_HIGH;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   sequence s_setup; PSEL_I && !PENABLE_I; endsequence
   sequence s_access; PSEL_I && PENABLE_I; endsequence
   property p_ready; s_access |-> PREADY_O; endproperty
   property p_err_when; PSLVERR_O |-> PSEL_I && PENABLE_I; endproperty
   property p_err_map; s_access |-> PSLVERR_O == !mapped; endproperty
   property p_rd_hold; !$past(PSEL_I && !PENABLE_I) |-> $stable(PRDATA_O); endproperty
   property p_rd_zero; s_setup ##0 (!mapped && !PWRITE_I) |=> PRDATA_O == 32'h00000000; endproperty
   property p_rd_upper; PRDATA_O[31:16] == 16'h0000; endproperty
   property p_tx_hold; !$past(TX_BIT_VALID_I) |-> $stable(TX_DATA_O); endproperty
   property p_tx_valid; TX_BIT_VALID_I |=> TX_BIT_VALID_O; endproperty
   a_ready:    assert property (p_ready) else $error("ready low in access");
   a_err_when: assert property (p_err_when) else $error("error outside access");
   a_err_map:  assert property (p_err_map) else $error("error flag wrong for address");
   a_rd_hold:  assert property (p_rd_hold) else $error("read data moved off setup");
   a_rd_zero:  assert property (p_rd_zero) else $error("unmapped read not zero");
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   a_tx_hold:  assert property (p_tx_hold) else $error("tx data moved without bit");
   a_tx_valid: assert property (p_tx_valid) else $error("tx valid not forwarded");
endmodule
bind bt_error_status bt_es_monitor i_mon (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TX_BIT_VALID_I(TX_BIT_VALID_I),
   .TX_BIT_VALID_O(TX_BIT_VALID_O), .TX_DATA_O(TX_DATA_O));

// [verification/tb_top.sv]
// self-checking bench for the tester error insertion and counters
`timescale 1ns/1ps
`include "bt_defines.vh"
module tb_top;
   reg         clk, rst_n, psel, pen, pwr, pm_req, port_en, pin, txv, txd, rxv, rxe, out_of_sync, err, ce, fl;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [7:0]  rnd;
   wire [31:0] prdata;
   wire        pready, pslverr, txv_o, txd_o, irq;
   integer     n_errors, n_compared, nb, ne, sb, se, lat, i, k, p, mc, mp, mq;
   bt_error_status i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .PM_UPDATE_REQUEST_I(pm_req),
      .PORT_STATUS_IRQ_EN_I(port_en), .EXT_ERROR_INSERT_PIN_I(pin), .TX_BIT_VALID_I(txv),
      .TX_DATA_I(txd), .TX_BIT_VALID_O(txv_o), .TX_DATA_O(txd_o), .RX_BIT_VALID_I(rxv),
      .RX_BIT_ERROR_I(rxe), .OUT_OF_SYNC_I(out_of_sync), .IRQ_O(irq));
   // pseudo random source, fixed start
   function [7:0] lf(input [7:0] s);
      lf = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task chk(input [31:0] s, input [31:0] e);
      begin
         n_compared = n_compared + 1;
         if (s !== e) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
         end
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task apb(input w, input [7:0] ix, input [31:0] d);
      begin
         @(posedge clk);
         psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= {2'b00, ix, 2'b00}; pwdata <= d;
         @(posedge clk);
         pen <= 1'b1;
         @(posedge clk);
         while (pready !== 1'b1) @(posedge clk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0; pen <= 1'b0;
      end
   endtask
   task wr(input [7:0] ix, input [31:0] d); apb(1'b1, ix, d); endtask
   task rdc(input [7:0] ix, input [31:0] e); begin apb(1'b0, ix, 0); chk(rd, e); end endtask
   // received bits with random errors; model keeps counts and latched flags
   task rx(input integer n, input o);
      begin
         if (o !== out_of_sync) lat = lat | 1;
         out_of_sync <= o;
         repeat (4) @(posedge clk);
         for (k = 0; k < n; k = k + 1) begin
            rnd = lf(rnd);
            @(posedge clk);
            rxv <= 1'b1; rxe <= rnd[0];
            if (rnd[0]) lat = lat | 4;
            if (!o) nb = nb + 1;
            if (!o && rnd[0]) begin
               if (ne == 0) lat = lat | 2;
               ne = ne + 1;
            end
            @(posedge clk);
            rxv <= 1'b0;
         end
         repeat (2) @(posedge clk);
      end
   endtask
   // model side of a counter update
   task upd; begin se = ne; sb = nb; ne = 0; nb = 0; lat = lat | 8; end endtask
   // transmit bits; model counts the rate period and applies a pending rate after each error
   task tx(input integer n, input one);
      begin
         for (k = 0; k < n; k = k + 1) begin
            rnd = lf(rnd);
            fl = one && k == 0;
            if (mp != 0) begin
               mc = mc + 1;
               if (mc == mp) begin
                  fl = 1'b1;
                  mc = 0;
                  mp = mq;
               end
            end
            @(posedge clk);
            txv <= 1'b1; txd <= rnd[1];
            @(posedge clk);
            txv <= 1'b0;
            #1 chk(txd_o, rnd[1] ^ fl);
         end
      end
   endtask
   task conclude;
      begin
         $display("compared %0d mismatches %0d", n_compared, n_errors);
         if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // watchdog, far beyond the expected run of some five thousand cycles
   initial begin
      #500000;
      n_errors = n_errors + 1;
      conclude;
   end
   initial begin
      {rst_n, psel, pen, pwr, pm_req, port_en, pin, txv, txd, rxv, rxe, out_of_sync, err} = 13'h0000;
      paddr = 12'h000; pwdata = 32'h00000000; rnd = 8'h15;
      n_errors = 0; n_compared = 0; nb = 0; ne = 0; sb = 0; se = 0; lat = 0; p = 1;
      ce = 1'b1; mc = 0; mp = 0; mq = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      // reset values, and refusal of the unused holes
      for (i = 8'h60; i <= 8'h7A; i = i + 2) begin
         rdc(i, 0);
         chk(err, !(i == 8'h60 || i == 8'h68 || (i >= 8'h6C && i != 8'h72)));
      end
      wr(`BT_IDX_IRQ_EN, 32'hFFFF);
      rdc(`BT_IDX_IRQ_EN, 32'h000F);
      // clock enable low: the write must be ignored
      ce <= 1'b0;
      wr(`BT_IDX_IRQ_EN, 32'h0000);
      ce <= 1'b1;
      rdc(`BT_IDX_IRQ_EN, 32'h000F);
      $display("test registers done");
      rx(20, 1'b0);
      rdc(`BT_IDX_LIVE_STATUS, (ne != 0) ? 2 : 0);
      rx(10, 1'b1);
      rdc(`BT_IDX_LIVE_STATUS, (ne != 0) ? 3 : 1);
      rx(6, 1'b0);
      rdc(`BT_IDX_LATCHED, lat);
      rdc(`BT_IDX_BIT_LOW, 0);
      wr(`BT_IDX_MON_CTRL, 32'h40);
      upd;
      repeat (3) @(posedge clk);
      rdc(`BT_IDX_LIVE_STATUS, 8);
      rdc(`BT_IDX_ERR_LOW, se & 32'hFFFF);
      rdc(`BT_IDX_ERR_HIGH, (se >> 16) & 32'hFF);
      rdc(`BT_IDX_BIT_LOW, sb & 32'hFFFF);
      rdc(`BT_IDX_BIT_HIGH, sb >> 16);
      rdc(`BT_IDX_LATCHED, lat);
      #1 chk(irq, 1);
      wr(`BT_IDX_LATCHED, 8);
      #1 chk(irq, 0);
      @(posedge clk);
      port_en <= 1'b1;
      @(posedge clk);
      #1 chk(irq, 1);
      wr(`BT_IDX_LATCHED, 15);
      #1 chk(irq, 0);
      wr(`BT_IDX_MON_CTRL, 0);
      rdc(`BT_IDX_LIVE_STATUS, 0);
      // global request path
      wr(`BT_IDX_MON_CTRL, 32'h80);
      rx(4, 1'b0);
      rdc(`BT_IDX_BIT_LOW, sb & 32'hFFFF);
      pm_req <= 1'b1;
      upd;
      repeat (3) @(posedge clk);
      rdc(`BT_IDX_BIT_LOW, sb & 32'hFFFF);
      rdc(`BT_IDX_LIVE_STATUS, (ne != 0) ? 10 : 8);
      pm_req <= 1'b0;
      repeat (3) @(posedge clk);
      rdc(`BT_IDX_LIVE_STATUS, (ne != 0) ? 2 : 0);
      $display("test counters done");
      // single insertion; triggers kept low while the source changes
      wr(`BT_IDX_INJ_CTRL, 6);
      wr(`BT_IDX_INJ_CTRL, 4);
      wr(`BT_IDX_INJ_CTRL, 6);
      tx(4, 1'b1);
      wr(`BT_IDX_INJ_CTRL, 0);
      wr(`BT_IDX_INJ_CTRL, 2);
      tx(4, 1'b0);
      wr(`BT_IDX_INJ_CTRL, 0);
      wr(`BT_IDX_INJ_CTRL, 5);
      wr(`BT_IDX_INJ_CTRL, 7);
      tx(4, 1'b0);
      wr(`BT_IDX_INJ_CTRL, 5);
      pin <= 1'b1;
      @(posedge clk);
      pin <= 1'b0;
      tx(4, 1'b1);
      wr(`BT_IDX_INJ_CTRL, 0);
      // rate insertion for the shorter rates; longer ones exceed the run budget
      // later rates are written mid-run, so they wait for the next error
      for (i = 1; i < 4; i = i + 1) begin
         p = p * 10;
         wr(`BT_IDX_INJ_CTRL, i << 3);
         mq = p;
         if (mp == 0) begin
            mp = p;
            mc = 0;
         end
         tx(2 * p, 1'b0);
      end
      wr(`BT_IDX_INJ_CTRL, 0);
      mp = 0;
      tx(12, 1'b0);
      $display("test insertion done");
      conclude;
   end
endmodule
